/* File: rtl/lgp_pin_ctrl.v */
// LED/GPIO pin control: done flags, direction, drive type, input level and change flags
`include "lgp_defs.vh"
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// - Set LED done flag when ramp completes
// - Status one LEDs 8..1, two 11..9
// - Host clearing global interrupt clears done
// - Deep sleep request clears done flags
// - Direction bit zero input, one output
// - Drive type applies only to outputs
// - Type zero open-drain, active pulls low
// - Type one push-pull, drives level
// - Input register follows live pin levels
// - Input pin change sets change flag
// - Flag and enable raise interrupt
// - Output pins take LED drive request
module lgp_pin_ctrl (
  // Clock and reset
  input wire sys_clk_in,
  input wire sys_rst_in,
  // Register port
  input wire [7:0] reg_addr_in,
  input wire reg_wr_in,
  input wire [7:0] reg_wdata_in,
  output reg [7:0] reg_rdata_out,
  // LED engine status
  input wire [10:0] led_ramp_done_in,
  input wire global_int_clear_in,
  input wire deep_sleep_request_in,
  // Pin drive request from LED output control and polarity
  input wire [7:0] led_drive_request_bit_in,
  input wire [7:0] led_polarity_in,
  // Change flag control
  input wire [7:0] pin_change_clear_in,
  input wire [7:0] pin_int_enable_in,
  // Shared pins
  input wire [7:0] pin_in,
  output reg [7:0] pin_out,
  output reg [7:0] pin_oe_out,
  // Status
  output wire [7:0] pin_change_flag_out,
  output wire pin_irq_out
);

  reg [10:0] led_done_flag_reg;
  reg [10:0] led_done_flag_next;
  reg [7:0] pin_direction_reg;
  reg [7:0] pin_drive_type_reg;
  reg [7:0] pin_input_level_reg;
  reg [7:0] pin_change_flag_reg;
  reg [7:0] pin_change_flag_next;
  reg [7:0] pin_drive_state;
  wire [7:0] sync_level;
  wire [7:0] sync_change;
  wire done_clear;
  integer i;
  // Both status bytes packed; the unused upper bits are cut off at reset
  wire [15:0] done_rst_value = {`LGP_RST_DONE_TWO, `LGP_RST_DONE_ONE};
  wire wr_direction;
  wire wr_drive_type;

  // ----------------------------------------
  // Helper functions
  // ----------------------------------------
  // Write strobe decode, shared by every writable offset
  function lgp_wr_hit;
    input wr;
    input [7:0] addr;
    input [7:0] target;
    begin
      lgp_wr_hit = wr && (addr == target);
    end
  endfunction

  // Polarity zero inverts the request
  function [7:0] lgp_drive_level;
    input [7:0] request;
    input [7:0] polarity;
    begin
      lgp_drive_level = request ^ ~polarity;
    end
  endfunction

  assign wr_direction = lgp_wr_hit(reg_wr_in, reg_addr_in, `LGP_ADDR_DIRECTION);
  assign wr_drive_type = lgp_wr_hit(reg_wr_in, reg_addr_in, `LGP_ADDR_DRIVE_TYPE);

  // ----------------------------------------
  // Pin synchroniser
  // ----------------------------------------
  lgp_pin_sync u_sync (
    .sys_clk_in(sys_clk_in),
    .sys_rst_in(sys_rst_in),
    .pin_raw_in(pin_in),
    .pin_level_out(sync_level),
    .pin_change_out(sync_change)
  );

  // ----------------------------------------
  // Done flags
  // ----------------------------------------
  // clear on interrupt clear or deep sleep request
  assign done_clear = global_int_clear_in | deep_sleep_request_in;

  // Set wins over a same-cycle clear so no completion is lost
  always @* begin
    led_done_flag_next = led_done_flag_reg & ~{`LGP_NUM_LEDS{done_clear}};
    led_done_flag_next = led_done_flag_next | led_ramp_done_in;
  end

  // ----------------------------------------
  // Change flags
  // ----------------------------------------
  // Set wins over a same-cycle clear so no edge is lost
  always @* begin
    pin_change_flag_next = pin_change_flag_reg & ~pin_change_clear_in;
    pin_change_flag_next = pin_change_flag_next | (sync_change & ~pin_direction_reg);
  end

  // ----------------------------------------
  // Register storage
  // ----------------------------------------
  always @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      led_done_flag_reg <= done_rst_value[`LGP_DONE_TWO_MSB:0];
      pin_direction_reg <= `LGP_RST_DIRECTION;
      pin_drive_type_reg <= `LGP_RST_DRIVE_TYPE;
      pin_input_level_reg <= `LGP_RST_INPUT_LEVEL;
      pin_change_flag_reg <= 8'h00;
    end else begin
      led_done_flag_reg <= led_done_flag_next;
      pin_change_flag_reg <= pin_change_flag_next;
      pin_input_level_reg <= sync_level;
      if (wr_direction) begin
        pin_direction_reg <= reg_wdata_in;
      end
      if (wr_drive_type) begin
        pin_drive_type_reg <= reg_wdata_in;
      end
    end
  end

  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  // Read data is registered; unmapped offsets read zero
  always @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      reg_rdata_out <= 8'h00;
    end else begin
      case (reg_addr_in)
        `LGP_ADDR_DONE_ONE: begin
          reg_rdata_out <= led_done_flag_reg[`LGP_DONE_ONE_MSB:`LGP_DONE_ONE_LSB];
        end
        `LGP_ADDR_DONE_TWO: begin
          reg_rdata_out <= {5'h00, led_done_flag_reg[`LGP_DONE_TWO_MSB:`LGP_DONE_TWO_LSB]};
        end
        `LGP_ADDR_DIRECTION: begin
          reg_rdata_out <= pin_direction_reg;
        end
        `LGP_ADDR_DRIVE_TYPE: begin
          reg_rdata_out <= pin_drive_type_reg;
        end
        `LGP_ADDR_INPUT_LEVEL: begin
          reg_rdata_out <= pin_input_level_reg;
        end
        default: begin
          reg_rdata_out <= 8'h00;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Pin drive
  // ----------------------------------------
  // request combined with polarity
  always @* begin
    pin_drive_state = lgp_drive_level(led_drive_request_bit_in, led_polarity_in);
  end

  // Registered so pins never glitch on config writes
  always @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      pin_out <= 8'h00;
      pin_oe_out <= 8'h00;
    end else begin
      for (i = 0; i < `LGP_NUM_PINS; i = i + 1) begin
        if (pin_direction_reg[i] == `LGP_DIR_INPUT) begin
          pin_out[i] <= 1'b0;
          pin_oe_out[i] <= 1'b0;
        end else if (pin_drive_type_reg[i] == `LGP_OT_OPEN_DRAIN) begin
          pin_out[i] <= 1'b0;
          pin_oe_out[i] <= pin_drive_state[i];
        end else begin
          pin_out[i] <= pin_drive_state[i];
          pin_oe_out[i] <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------
  // Interrupt
  // ----------------------------------------
  assign pin_change_flag_out = pin_change_flag_reg;
  assign pin_irq_out = |(pin_change_flag_reg & pin_int_enable_in);

endmodule
`default_nettype wire

/* File: rtl/lgp_defs.vh */
// Register offsets, reset values and field positions of the LED/GPIO pin block
`ifndef LGP_DEFS_VH
`define LGP_DEFS_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define LGP_ADDR_DONE_ONE 8'h60
`define LGP_ADDR_DONE_TWO 8'h61
`define LGP_ADDR_DIRECTION 8'h70
`define LGP_ADDR_DRIVE_TYPE 8'h71
`define LGP_ADDR_INPUT_LEVEL 8'h72

// ----------------------------------------
// Reset values
// ----------------------------------------
`define LGP_RST_DONE_ONE 8'h00
`define LGP_RST_DONE_TWO 8'h00
`define LGP_RST_DIRECTION 8'h00
`define LGP_RST_DRIVE_TYPE 8'h00
`define LGP_RST_INPUT_LEVEL 8'h00

// ----------------------------------------
// Field layout
// ----------------------------------------
`define LGP_DONE_ONE_LSB 0
`define LGP_DONE_ONE_MSB 7
`define LGP_DONE_TWO_LSB 8
`define LGP_DONE_TWO_MSB 10
`define LGP_NUM_PINS 8
`define LGP_NUM_LEDS 11
`define LGP_OT_OPEN_DRAIN 1'b0
`define LGP_OT_PUSH_PULL 1'b1
`define LGP_DIR_INPUT 1'b0
`define LGP_DIR_OUTPUT 1'b1

`endif

/* File: rtl/lgp_pin_sync.v */
// Two-stage synchroniser with change detection for the shared pins
`timescale 1ns/100ps
`default_nettype none
module lgp_pin_sync (
  // Clock and reset
  input wire sys_clk_in,
  input wire sys_rst_in,
  // Raw pins
  input wire [7:0] pin_raw_in,
  // Synchronised level and change pulses
  output wire [7:0] pin_level_out,
  output wire [7:0] pin_change_out
);

  reg [7:0] meta_reg;
  reg [7:0] sync_reg;
  reg [7:0] prev_reg;

  // ----------------------------------------
  // Synchroniser
  // ----------------------------------------
  // sync before compare
  always @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      meta_reg <= 8'h00;
      sync_reg <= 8'h00;
      prev_reg <= 8'h00;
    end else begin
      meta_reg <= pin_raw_in;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  assign pin_level_out = sync_reg;
  assign pin_change_out = sync_reg ^ prev_reg;

endmodule
`default_nettype wire

/* File: tb/lgp_pin_model.sv */
// Far side of the shared pins: pull-ups and an outside driver
`timescale 1ns/100ps
`default_nettype none
module lgp_pin_model (
  // Device and outside drivers
  input wire logic [7:0] dev_out_in,
  input wire logic [7:0] dev_oe_in,
  input wire logic [7:0] ext_oe_in,
  // Resolved levels
  output logic [7:0] pin_level_out
);
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      pin_level_out[i] = dev_oe_in[i] ? dev_out_in[i] : !ext_oe_in[i];
    end
  end
endmodule
`default_nettype wire

/* File: tb/lgp_pin_ctrl_sva.sv */
// Assertions on the LED/GPIO pin block ports
`timescale 1ns/100ps
`default_nettype none
module lgp_pin_ctrl_sva (
  // Watched ports
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [10:0] led_ramp_done_in,
  input wire logic global_int_clear_in,
  input wire logic deep_sleep_request_in,
  input wire logic [7:0] led_drive_request_bit_in,
  input wire logic [7:0] led_polarity_in,
  input wire logic [7:0] pin_change_clear_in,
  input wire logic [7:0] pin_int_enable_in,
  input wire logic [7:0] pin_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe_out,
  input wire logic [7:0] pin_change_flag_out,
  input wire logic pin_irq_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (sys_rst_in);
  sequence s_led1_done;
    led_ramp_done_in[0] && !global_int_clear_in && !deep_sleep_request_in ##1 reg_addr_in == 8'h60;
  endsequence
  sequence s_clear_read;
    global_int_clear_in && led_ramp_done_in == 11'h000 ##1 reg_addr_in == 8'h60;
  endsequence
  a_done_set: assert property (s_led1_done |=> reg_rdata_out[0]) else $error("done flag not set");
  a_done_clr: assert property (s_clear_read |=> reg_rdata_out == 8'h00) else $error("done not cleared");
  a_dir_input: assert property (reg_addr_in == 8'h70 |=>
    (pin_oe_out & ~reg_rdata_out) == 8'h00) else $error("input pin driven");
  a_open_drain: assert property (reg_addr_in == 8'h71 |=>
    (pin_oe_out & ~reg_rdata_out & pin_out) == 8'h00) else $error("open-drain drove high");
  a_push_pull: assert property (reg_addr_in == 8'h71 |=> (pin_oe_out & reg_rdata_out &
    (pin_out ^ $past(led_drive_request_bit_in ^ ~led_polarity_in))) == 8'h00) else $error("push-pull level");
  a_irq_flag: assert property (pin_irq_out == |(pin_change_flag_out & pin_int_enable_in))
    else $error("irq mismatch");
  a_input_level: assert property ($stable(pin_in)[*5] ##0 reg_addr_in == 8'h72 |=>
    reg_rdata_out == $past(pin_in)) else $error("input level");
  a_flag_sticky: assert property (pin_change_flag_out[0] && !pin_change_clear_in[0] |=>
    pin_change_flag_out[0]) else $error("flag dropped");
endmodule
bind lgp_pin_ctrl lgp_pin_ctrl_sva i_lgp_pin_ctrl_sva (.sys_clk_in, .sys_rst_in, .reg_addr_in, .led_ramp_done_in,
  .global_int_clear_in, .deep_sleep_request_in, .led_drive_request_bit_in, .led_polarity_in, .pin_change_clear_in,
  .pin_int_enable_in, .pin_in, .reg_rdata_out, .pin_out, .pin_oe_out, .pin_change_flag_out, .pin_irq_out);
`default_nettype wire

/* File: tb/lgp_pin_ctrl_bench.sv */
// Self-checking bench for the LED/GPIO pin block
`timescale 1ns/100ps
`default_nettype none
module lgp_pin_ctrl_bench;
  logic clk, rst, wr, gclr, slp, irq;
  logic [7:0] addr, wdat, rdat, req, pol, clr, ien, pins, pout, poe, flag, ext;
  logic [10:0] ramp;
  int fails, n_compared;
  lgp_pin_ctrl i_lgp_pin_ctrl (.sys_clk_in(clk), .sys_rst_in(rst), .reg_addr_in(addr), .reg_wr_in(wr),
    .reg_wdata_in(wdat), .reg_rdata_out(rdat), .led_ramp_done_in(ramp), .global_int_clear_in(gclr),
    .deep_sleep_request_in(slp), .led_drive_request_bit_in(req), .led_polarity_in(pol), .pin_change_clear_in(clr),
    .pin_int_enable_in(ien), .pin_in(pins), .pin_out(pout), .pin_oe_out(poe), .pin_change_flag_out(flag),
    .pin_irq_out(irq));
  lgp_pin_model i_lgp_pin_model (.dev_out_in(pout), .dev_oe_in(poe), .ext_oe_in(ext), .pin_level_out(pins));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic ticks(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    addr = a;
    wdat = d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
  endtask
  task automatic rreg(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk);
    addr = a;
    @(negedge clk);
    check(rdat, exp);
  endtask
  // Startup level change flags all pins; clear them first
  task automatic t_reset_regs;
    rreg(8'h70, 8'h00);
    rreg(8'h71, 8'h00);
    rreg(8'h61, 8'h00);
    wreg(8'h60, 8'hff);
    rreg(8'h60, 8'h00);
    rreg(8'h90, 8'h00);
    clr = 8'hff;
    ticks(1);
    clr = 8'h00;
    ticks(1);
    check(flag, 8'h00);
  endtask
  task automatic t_pin_change;
    ien = 8'h01;
    ext = 8'h01;
    ticks(6);
    check(flag, 8'h01);
    check({7'h00, irq}, 8'h01);
    rreg(8'h72, 8'hfe);
    ien = 8'h00;
    clr = 8'h01;
    ticks(1);
    clr = 8'h00;
    ticks(1);
    check({flag[0], irq}, 8'h00);
    // Make pin 0 an open-drain output, left undriven, so its level change sets no flag
    pol = 8'h01;
    wreg(8'h70, 8'h01);
    ext = 8'h00;
    ticks(6);
    check(flag, 8'h00);
    rreg(8'h72, 8'hff);
  endtask
  task automatic t_drive;
    wreg(8'h71, 8'h0f);
    wreg(8'h70, 8'hff);
    req = 8'hff;
    pol = 8'hff;
    ticks(3);
    check(poe, 8'hff);
    check(pout, 8'h0f);
    req = 8'h00;
    ticks(3);
    check(poe, 8'h0f);
    check(pins, 8'hf0);
    pol = 8'h00;
    wreg(8'h70, 8'h0f);
    ticks(3);
    check(poe, 8'h0f);
    check(pout, 8'h0f);
  endtask
  task automatic t_done;
    ramp = 11'h501;
    ticks(1);
    ramp = 11'h000;
    rreg(8'h60, 8'h01);
    rreg(8'h61, 8'h05);
    gclr = 1'b1;
    ticks(1);
    gclr = 1'b0;
    rreg(8'h61, 8'h00);
    ramp = 11'h7ff;
    ticks(1);
    ramp = 11'h000;
    rreg(8'h61, 8'h07);
    slp = 1'b1;
    ticks(1);
    slp = 1'b0;
    rreg(8'h60, 8'h00);
    ramp = 11'h001;
    gclr = 1'b1;
    ticks(1);
    ramp = 11'h000;
    gclr = 1'b0;
    rreg(8'h60, 8'h01);
  endtask
  task automatic give_verdict;
    $display("compared=%0d fails=%0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    {rst, wr, gclr, slp, addr, wdat, req, pol, clr, ien, ext, ramp} = {1'b1, 70'h0};
    ticks(4);
    rst = 1'b0;
    t_reset_regs;
    t_pin_change;
    t_drive;
    t_done;
    give_verdict;
  end
endmodule
`default_nettype wire
